// ===== hdl/asb_ctrl.sv
// Operation
// - Scan bit steps channel-zero positive inputs
// - 12-bit mode hides channel count, reads zero
// - Channel count picks channels zero..three
// - Status one while second half fills
// - Status zero while first half fills
// - Without DMA, interrupt every N+1, four bits
// - With DMA, address step every N+1, five bits
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "asb_params.svh"
module asb_ctrl
  import asb_pkg::*;
#(
  parameter int SCAN_W = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SCAN_W-1:0] scan_inputs,
  input wire logic conversion_done,
  input wire logic buffer_wrap,
  output logic input_scan_select,
  output logic [3:0] channels_active,
  output logic [2:0] reference_pair_select,
  output logic [4:0] scan_position,
  output logic converter_interrupt,
  output logic dma_address_step,
  output logic irq
);
  asb_word_t ctrl2;
  logic conv_on;
  logic converter_dma_enable;
  logic resolution_select;
  logic buffer_half_status;
  logic [1:0] irq_stat;
  logic [1:0] irq_en;
  logic [4:0] scan_pos;
  logic [4:0] next_scan_pos;
  logic acc_ok;
  logic wr;
  logic rd;
  logic [31:0] next_prdata;

  asb_count_if cif ();

  asb_event_counter u_count (
    .clk(clk),
    .rst_b(rst_b),
    .cnt(cif)
  );

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  assign acc_ok = psel && penable;
  assign wr = acc_ok && pwrite;
  assign rd = acc_ok && !pwrite;
  assign pready = 1'b1;

  // Unmapped addresses answer with an error; no register changes.
  always_comb begin
    pslverr = 1'b0;
    if (acc_ok) begin
      if (addr_is(paddr, `ASB_OFS_CTRL2)) begin
        pslverr = 1'b0;
      end else if (addr_is(paddr, `ASB_OFS_ENABLE)) begin
        pslverr = 1'b0;
      end else if (addr_is(paddr, `ASB_OFS_STATUS)) begin
        pslverr = 1'b0;
      end else if (addr_is(paddr, `ASB_OFS_IRQ_STAT)) begin
        pslverr = 1'b0;
      end else if (addr_is(paddr, `ASB_OFS_IRQ_CLR)) begin
        pslverr = 1'b0;
      end else if (addr_is(paddr, `ASB_OFS_IRQ_EN)) begin
        pslverr = 1'b0;
      end else begin
        pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl2 <= `ASB_CTRL2_RESET;
    end else if (wr && addr_is(paddr, `ASB_OFS_CTRL2)) begin
      ctrl2 <= pwdata[15:0] & `ASB_CTRL2_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_on <= 1'b0;
      converter_dma_enable <= 1'b0;
      resolution_select <= 1'b0;
    end else if (wr && addr_is(paddr, `ASB_OFS_ENABLE)) begin
      conv_on <= pwdata[`ASB_EN_ON_BIT];
      converter_dma_enable <= pwdata[`ASB_EN_DMA_BIT];
      resolution_select <= pwdata[`ASB_EN_RES_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en <= 2'h0;
    end else if (wr && addr_is(paddr, `ASB_OFS_IRQ_EN)) begin
      irq_en <= pwdata[`ASB_IRQ_W-1:0];
    end
  end

  assign cif.limit = converter_dma_enable ? ctrl2[`ASB_CONVERSIONS_PER_EVENT_HI:`ASB_CONVERSIONS_PER_EVENT_LO]
                                          : {1'b0, ctrl2[`ASB_CONVERSIONS_PER_EVENT_HI-1:`ASB_CONVERSIONS_PER_EVENT_LO]};
  assign cif.conv_done = conv_on && conversion_done;
  assign cif.clear = !conv_on;

  // Event outputs are registered so that consumers see a clean one-cycle pulse.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      converter_interrupt <= 1'b0;
      dma_address_step <= 1'b0;
    end else begin
      converter_interrupt <= cif.hit && !converter_dma_enable;
      dma_address_step <= cif.hit && converter_dma_enable;
    end
  end

  // A new event wins over a simultaneous software clear.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat <= (irq_stat & ~((wr && addr_is(paddr, `ASB_OFS_IRQ_CLR))
                                ? pwdata[`ASB_IRQ_W-1:0] : 2'h0))
                  | {cif.hit && converter_dma_enable, cif.hit && !converter_dma_enable};
    end
  end

  assign irq = |(irq_stat & irq_en);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      buffer_half_status <= 1'b0;
    end else if (!conv_on || !ctrl2[`ASB_SPLIT_BUFFER_MODE_BIT]) begin
      buffer_half_status <= 1'b0;
    end else if (buffer_wrap) begin
      buffer_half_status <= !buffer_half_status;
    end
  end

  always_comb begin
    next_scan_pos = scan_pos;
    if (!ctrl2[`ASB_SCAN_BIT] || !conv_on) begin
      next_scan_pos = 5'h0;
    end else if (conversion_done) begin
      next_scan_pos = scan_pos;
      for (int i = SCAN_W - 1; i >= 0; i--) begin
        if (5'(i) > scan_pos && scan_inputs[i]) begin
          next_scan_pos = 5'(i);
        end
      end
      if (next_scan_pos == scan_pos) begin
        for (int i = SCAN_W - 1; i >= 0; i--) begin
          if (scan_inputs[i]) begin
            next_scan_pos = 5'(i);
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scan_pos <= 5'h0;
    end else begin
      scan_pos <= next_scan_pos;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      input_scan_select <= 1'b0;
      reference_pair_select <= 3'h0;
      scan_position <= 5'h0;
      channels_active <= 4'h0;
    end else begin
      input_scan_select <= ctrl2[`ASB_SCAN_BIT];
      reference_pair_select <= ctrl2[`ASB_REF_HI:`ASB_REF_LO];
      scan_position <= next_scan_pos;
      if (resolution_select) begin
        channels_active <= 4'h1;
      end else if (ctrl2[`ASB_CHANNEL_COUNT_SELECT_HI]) begin
        channels_active <= 4'hF;
      end else if (ctrl2[`ASB_CHANNEL_COUNT_SELECT_LO]) begin
        channels_active <= 4'h3;
      end else begin
        channels_active <= 4'h1;
      end
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (addr_is(paddr, `ASB_OFS_CTRL2)) begin
      next_prdata[15:0] = ctrl2;
      if (resolution_select) begin
        next_prdata[`ASB_CHANNEL_COUNT_SELECT_HI:`ASB_CHANNEL_COUNT_SELECT_LO] = 2'h0;
      end
      next_prdata[`ASB_BUFFER_HALF_STATUS_BIT] = buffer_half_status;
    end else if (addr_is(paddr, `ASB_OFS_ENABLE)) begin
      next_prdata[`ASB_EN_ON_BIT] = conv_on;
      next_prdata[`ASB_EN_DMA_BIT] = converter_dma_enable;
      next_prdata[`ASB_EN_RES_BIT] = resolution_select;
    end else if (addr_is(paddr, `ASB_OFS_STATUS)) begin
      next_prdata[4:0] = cif.count;
      next_prdata[12:8] = scan_pos;
    end else if (addr_is(paddr, `ASB_OFS_IRQ_STAT)) begin
      next_prdata[`ASB_IRQ_W-1:0] = irq_stat;
    end else if (addr_is(paddr, `ASB_OFS_IRQ_EN)) begin
      next_prdata[`ASB_IRQ_W-1:0] = irq_en;
    end
  end

  // Read data is captured in the setup cycle so it is stable in the access phase.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end
endmodule // asb_ctrl
`default_nettype wire

// ===== hdl/asb_params.svh
`ifndef ASB_PARAMS_SVH
`define ASB_PARAMS_SVH

// Register byte offsets on the APB.
`define ASB_OFS_CTRL2 12'h000
`define ASB_OFS_ENABLE 12'h004
`define ASB_OFS_STATUS 12'h008
`define ASB_OFS_IRQ_STAT 12'h00C
`define ASB_OFS_IRQ_CLR 12'h010
`define ASB_OFS_IRQ_EN 12'h014

// Field positions inside the second control register.
`define ASB_REF_HI 15
`define ASB_REF_LO 13
`define ASB_SCAN_BIT 10
`define ASB_CHANNEL_COUNT_SELECT_HI 9
`define ASB_CHANNEL_COUNT_SELECT_LO 8
`define ASB_BUFFER_HALF_STATUS_BIT 7
`define ASB_CONVERSIONS_PER_EVENT_HI 6
`define ASB_CONVERSIONS_PER_EVENT_LO 2
`define ASB_SPLIT_BUFFER_MODE_BIT 1
`define ASB_ALT_BIT 0

// Writable bits of the second control register.
`define ASB_CTRL2_WMASK 16'hE77F
`define ASB_CTRL2_RESET 16'h0000

// Enable register fields.
`define ASB_EN_ON_BIT 0
`define ASB_EN_DMA_BIT 1
`define ASB_EN_RES_BIT 2

// Interrupt status bits.
`define ASB_IRQ_CONV 0
`define ASB_IRQ_DMA 1
`define ASB_IRQ_W 2

`endif

// ===== hdl/asb_pkg.sv
package asb_pkg;
  typedef enum logic [2:0] {
    ASB_SEL_CH0 = 3'b001,
    ASB_SEL_CH1 = 3'b010,
    ASB_SEL_CH2 = 3'b100
  } asb_chsel_t;
  typedef logic [15:0] asb_word_t;
endpackage

// ===== hdl/asb_count_if.sv
`timescale 1ns/10ps
`default_nettype none
interface asb_count_if;
  logic clear;
  logic conv_done;
  logic [4:0] limit;
  logic hit;
  logic [4:0] count;
  modport ctrl (output clear, output conv_done, output limit, input hit, input count);
  modport counter (input clear, input conv_done, input limit, output hit, output count);
endinterface
`default_nettype wire

// ===== hdl/asb_event_counter.sv
`timescale 1ns/10ps
`default_nettype none
module asb_event_counter
  import asb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  asb_count_if.counter cnt
);
  logic [4:0] count;

  // Hit fires on the conversion that arrives with the count already at the programmed limit.
  assign cnt.hit = cnt.conv_done && (count == cnt.limit);
  assign cnt.count = count;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 5'h0;
    end else if (cnt.clear || cnt.hit) begin
      count <= 5'h0;
    end else if (cnt.conv_done) begin
      count <= count + 5'h1;
    end
  end
endmodule // asb_event_counter
`default_nettype wire

// ===== verif/asb_conv_model.sv
`timescale 1ns/10ps
`default_nettype none
module asb_conv_model (
  input wire logic clk,
  output logic conversion_done,
  output logic buffer_wrap
);
  initial begin
    conversion_done = 1'b0;
    buffer_wrap = 1'b0;
  end
  // The gap varies so the block sees both dense and spaced conversions.
  task automatic run(input int n, input logic wrap, input int gap);
    for (int c = 0; c < n; c++) begin
      @(posedge clk);
      conversion_done <= 1'b1;
      buffer_wrap <= wrap;
      @(posedge clk);
      conversion_done <= 1'b0;
      buffer_wrap <= 1'b0;
      repeat (gap) @(posedge clk);
    end
  endtask
endmodule // asb_conv_model
`default_nettype wire

// ===== verif/asb_ctrl_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "asb_params.svh"
module asb_ctrl_asserts #(
  parameter int SCAN_W = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic conversion_done,
  input wire logic input_scan_select,
  input wire logic [3:0] channels_active,
  input wire logic converter_interrupt,
  input wire logic dma_address_step,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic wr;
  logic res_q;
  logic dma_q;
  logic scan_q;
  logic [1:0] channel_count_select_q;
  assign wr = psel && penable && pwrite;
  // Shadow copies let the checks wait until a setting has settled.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      res_q <= 1'b0;
      dma_q <= 1'b0;
      scan_q <= 1'b0;
      channel_count_select_q <= 2'b00;
    end else if (wr && paddr == `ASB_OFS_ENABLE) begin
      res_q <= pwdata[`ASB_EN_RES_BIT];
      dma_q <= pwdata[`ASB_EN_DMA_BIT];
    end else if (wr && paddr == `ASB_OFS_CTRL2) begin
      scan_q <= pwdata[`ASB_SCAN_BIT];
      channel_count_select_q <= pwdata[`ASB_CHANNEL_COUNT_SELECT_HI:`ASB_CHANNEL_COUNT_SELECT_LO];
    end
  end
  a_scan_copy: assert property ($stable(scan_q) [*3] |-> input_scan_select == scan_q)
    else $error("scan select differs from control bit");
  a_res_single: assert property (res_q [*3] |-> channels_active == 4'h1)
    else $error("channel count active in 12-bit mode");
  a_chan_map: assert property (($stable({channel_count_select_q, res_q}) && !res_q) [*3] |->
    channels_active == (channel_count_select_q[1] ? 4'hF : channel_count_select_q[0] ? 4'h3 : 4'h1))
    else $error("active channels do not match count field");
  a_int_cause: assert property (converter_interrupt |-> $past(conversion_done))
    else $error("interrupt pulse without a conversion");
  a_step_cause: assert property (dma_address_step |-> $past(conversion_done))
    else $error("address step without a conversion");
  a_int_nodma: assert property (dma_q [*3] |-> !converter_interrupt)
    else $error("interrupt pulse while DMA enabled");
  a_step_nodma: assert property (!dma_q [*3] |-> !dma_address_step)
    else $error("address step while DMA disabled");
  a_irq_cause: assert property ($rose(irq) |->
    converter_interrupt || dma_address_step || $past(wr))
    else $error("irq rose without an event or write");
endmodule // asb_ctrl_asserts
bind asb_ctrl asb_ctrl_asserts #(.SCAN_W(SCAN_W)) u_asserts (.clk(clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .conversion_done(conversion_done), .input_scan_select(input_scan_select),
  .channels_active(channels_active), .converter_interrupt(converter_interrupt),
  .dma_address_step(dma_address_step), .irq(irq));
`default_nettype wire

// ===== verif/test_asb_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "asb_params.svh"
module test_asb_ctrl;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [15:0] scan_inputs = 16'h0001;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, input_scan_select, converter_interrupt, dma_address_step, irq;
  logic conversion_done, buffer_wrap, half;
  logic [3:0] channels_active;
  logic [2:0] reference_pair_select;
  logic [4:0] scan_position;
  logic [4:0] tbl [6] = '{5'h00, 5'h13, 5'h1F, 5'h00, 5'h1F, 5'h05};
  integer seed = 32'h1ad6_7fb0;
  int mismatches = 0;
  int check_count = 0;
  int n_int = 0;
  int n_dma = 0;
  int n, per, i, b_int, b_dma, dma, p;
  // Reference scan order: next higher enabled input, else wrap to the lowest one.
  function automatic int next_pos(input int cur, input logic [15:0] m);
    for (int j = cur + 1; j < 16; j++) begin
      if (m[j]) return j;
    end
    for (int j = 0; j < 16; j++) begin
      if (m[j]) return j;
    end
    return cur;
  endfunction
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (converter_interrupt === 1'b1) n_int <= n_int + 1;
    if (dma_address_step === 1'b1) n_dma <= n_dma + 1;
  end
  asb_ctrl u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scan_inputs(scan_inputs), .conversion_done(conversion_done), .buffer_wrap(buffer_wrap),
    .input_scan_select(input_scan_select), .channels_active(channels_active),
    .reference_pair_select(reference_pair_select), .scan_position(scan_position),
    .converter_interrupt(converter_interrupt), .dma_address_step(dma_address_step), .irq(irq));
  asb_conv_model u_conv (.clk(clk), .conversion_done(conversion_done), .buffer_wrap(buffer_wrap));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (exp !== got) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One idle edge first, so a release and a new setup never share a time step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    scan_inputs <= 16'($random(seed));
    for (i = 0; i < 4; i++) begin
      n = $random(seed);
      n[9:8] = i;
      apb(1'b1, `ASB_OFS_CTRL2, n);
      apb(1'b0, `ASB_OFS_CTRL2, 0);
      chk("ctrl2", n & `ASB_CTRL2_WMASK, rd);
      chk("channels", i == 0 ? 1 : i == 1 ? 3 : 15, channels_active);
      chk("scan", n[10], input_scan_select);
      chk("reference pair", n[15:13], reference_pair_select);
    end
    apb(1'b1, `ASB_OFS_ENABLE, 32'h0000_0004);
    apb(1'b1, `ASB_OFS_CTRL2, 32'h0000_0300);
    apb(1'b0, `ASB_OFS_CTRL2, 0);
    chk("ctrl2 12-bit", 0, rd);
    chk("channels 12-bit", 1, channels_active);
    for (i = 0; i < 6; i++) begin
      dma = i / 3;
      per = dma ? tbl[i] + 1 : tbl[i][3:0] + 1;
      n = 1 + ($random(seed) & 63);
      apb(1'b1, `ASB_OFS_CTRL2, 32'({tbl[i], 2'b00}));
      apb(1'b1, `ASB_OFS_ENABLE, 32'({dma[0], 1'b1}));
      b_int = n_int;
      b_dma = n_dma;
      u_conv.run(n, 1'b0, i);
      repeat (3) @(posedge clk);
      chk("interrupts", dma ? 0 : n / per, n_int - b_int);
      chk("address steps", dma ? n / per : 0, n_dma - b_dma);
      apb(1'b0, `ASB_OFS_STATUS, 0);
      chk("counter", n % per, rd[4:0]);
      apb(1'b1, `ASB_OFS_ENABLE, 0);
      apb(1'b0, `ASB_OFS_STATUS, 0);
      chk("counter off", 0, rd[4:0]);
    end
    apb(1'b1, `ASB_OFS_CTRL2, 32'h0000_0002);
    apb(1'b1, `ASB_OFS_ENABLE, 32'h0000_0001);
    apb(1'b1, `ASB_OFS_IRQ_CLR, 32'h0000_0003);
    apb(1'b1, `ASB_OFS_IRQ_EN, 0);
    half = 1'b0;
    for (i = 0; i < 3; i++) begin
      u_conv.run(1, 1'b1, 0);
      half = ~half;
      apb(1'b0, `ASB_OFS_CTRL2, 0);
      chk("half status", half, rd[7]);
    end
    chk("irq masked", 0, irq);
    apb(1'b1, `ASB_OFS_IRQ_STAT, 0);
    apb(1'b0, `ASB_OFS_IRQ_STAT, 0);
    chk("irq status", 1, rd);
    apb(1'b1, `ASB_OFS_IRQ_EN, 32'h0000_0001);
    // The write lands at the edge the task returns on; let it settle first.
    @(posedge clk);
    chk("irq enabled", 1, irq);
    apb(1'b1, `ASB_OFS_IRQ_CLR, 32'h0000_0001);
    @(posedge clk);
    chk("irq cleared", 0, irq);
    apb(1'b1, `ASB_OFS_CTRL2, 0);
    apb(1'b0, `ASB_OFS_CTRL2, 0);
    chk("half outside split", 0, rd[7]);
    apb(1'b0, 12'h018, 0);
    chk("unmapped error", 1, err);
    scan_inputs <= 16'($random(seed)) | 16'h0101;
    apb(1'b1, `ASB_OFS_CTRL2, 32'h0000_0400);
    apb(1'b1, `ASB_OFS_ENABLE, 32'h0000_0001);
    p = 0;
    for (i = 0; i < 6; i++) begin
      u_conv.run(1, 1'b0, 0);
      @(posedge clk);
      p = next_pos(p, scan_inputs);
      chk("scan position", p, scan_position);
    end
    tally_and_finish();
  end
endmodule // test_asb_ctrl
`default_nettype wire
